//--- shared/usbc_pkg.sv
package usbc_pkg;

  localparam int unsigned NUM_EP  = 5;
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned INT_W   = 11;

  // register byte addresses
  localparam logic [11:0] OFS_FUNCTION_ADDRESS_REG    = 12'h000;
  localparam logic [11:0] OFS_POWER    = 12'h004;
  localparam logic [11:0] OFS_INT_STS  = 12'h008;
  localparam logic [11:0] OFS_INT_EN   = 12'h00C;
  localparam logic [11:0] OFS_INDEX    = 12'h010;
  localparam logic [11:0] OFS_DEVCTL   = 12'h014;
  localparam logic [11:0] OFS_PHY_CTL  = 12'h018;
  localparam logic [11:0] OFS_IDX_WIN  = 12'h410;
  localparam logic [11:0] OFS_FLAT_LO  = 12'h500;
  localparam logic [11:0] OFS_FLAT_HI  = 12'h54F;

  // word inside an endpoint slot
  localparam logic [1:0] W_CSR   = 2'h0;
  localparam logic [1:0] W_TXCFG = 2'h1;
  localparam logic [1:0] W_RXCFG = 2'h2;

  // power register fields
  localparam int unsigned POW_SOFT_CONN = 6;
  localparam int unsigned POW_HS_EN     = 5;
  localparam int unsigned POW_HS_ACT    = 4;
  localparam int unsigned POW_RESUME    = 3;
  localparam int unsigned POW_SUSPEND   = 1;

  // phy control fields
  localparam int unsigned PHY_LOCK_BIT = 8;
  localparam logic [5:0]  PHY_CTL_RST  = 6'h00;

  // interrupt status fields, endpoints occupy bits 4:0
  localparam int unsigned INT_SUSPEND = 5;
  localparam int unsigned INT_RESUME  = 6;
  localparam int unsigned INT_RESET   = 7;
  localparam int unsigned INT_SOF     = 8;
  localparam int unsigned INT_CONN    = 9;
  localparam int unsigned INT_DISC    = 10;

  // fifo configuration word
  localparam logic [31:0] EP0_FIFO_CFG = 32'h0000_0040;
  localparam logic [3:0]  SETUP_LEN    = 4'h8;

  // bus idle before suspend
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned SUSPEND_US     = 3000;
  localparam int unsigned SUSPEND_CYCLES = SUSPEND_US * CLK_MHZ;

  typedef enum logic {ST_ACTIVE, ST_SUSPEND} usbc_link_st_e;

  typedef struct packed {
    logic session_end_detect_enable;
    logic vbus_detect_enable;
    logic phy_power_down;
    logic phy_pll_disable;
    logic osc_power_down;
    logic ref_freq_select;
  } usbc_phy_ctl_s;

  typedef struct packed {
    logic bus_activity;
    logic bus_reset;
    logic resume_sig;
    logic sof;
    logic connect;
    logic disconnect;
    logic hs_chirp_ok;
  } usbc_link_evt_s;

  typedef struct packed {
    logic       valid;
    logic [3:0] length;
  } usbc_setup_s;

endpackage

//--- rtl/usbc_core.sv
`timescale 1ns/10ps
module usbc_core #(
  parameter int unsigned SUSP_CYC = usbc_pkg::SUSPEND_CYCLES
) (
  input  wire logic                      clk_i,
  input  wire logic                      arst_n_i,
  input  wire logic [11:0]               addr_i,
  input  wire logic [31:0]               wdata_i,
  input  wire logic                      we_i,
  input  wire logic                      re_i,
  output logic      [31:0]               rdata_o,
  input  wire usbc_pkg::usbc_link_evt_s  link_i,
  input  wire usbc_pkg::usbc_setup_s     setup_i,
  input  wire logic [4:0]                xfer_done_i,
  input  wire logic                      id_a_end_i,
  input  wire logic                      pll_locked_i,
  output usbc_pkg::usbc_phy_ctl_s        phy_ctl_o,
  output logic                           soft_connect_o,
  output logic                           host_mode_o,
  output logic                           suspend_o,
  output logic                           resume_drive_o,
  output logic                           hs_attempt_o,
  output logic                           hs_active_o,
  output logic      [4:0]                fifo_flush_o,
  output logic                           setup_reject_o,
  output logic      [6:0]                function_address_reg_o,
  output logic                           irq_o
);
  import usbc_pkg::*;

  function automatic logic [2:0] ep_of(input logic [11:0] a, input logic [3:0] idx,
                                       input logic indexed);
    ep_of = indexed ? idx[2:0] : a[6:4];
  endfunction

  logic [6:0]        function_address_reg_q;
  logic [3:0]        index_q;
  logic              soft_conn_q;
  logic              hs_en_q;
  logic              hs_act_q;
  logic              resume_q;
  logic              resume_prev_q;
  usbc_phy_ctl_s     phy_q;
  logic [INT_W-1:0]  ists_q;
  logic [INT_W-1:0]  ien_q;
  logic              host_q;
  logic              rst_prev_q;
  logic [31:0]       idle_cnt_q;
  usbc_link_st_e     st_q;
  usbc_link_st_e     st_d;
  logic [15:0]       csr_q   [NUM_EP];
  logic [31:0]       txcfg_q [NUM_EP];
  logic [31:0]       rxcfg_q [NUM_EP];
  logic [31:0]       rdata_q;
  logic              irq_q;
  logic [4:0]        flush_q;
  logic              reject_q;
  logic              drive_q;
  logic              hs_try_q;

  // address decode
  wire         in_idx   = (addr_i[11:4] == OFS_IDX_WIN[11:4]);
  wire         in_flat  = (addr_i >= OFS_FLAT_LO) && (addr_i <= OFS_FLAT_HI);
  wire         idx_ok   = (index_q < 4'(NUM_EP));
  wire         ep_hit   = (in_idx && idx_ok) || in_flat;
  wire [2:0]   ep_sel   = ep_of(addr_i, index_q, in_idx);
  wire [1:0]   ep_word  = addr_i[3:2];
  wire         wr_ep    = we_i && ep_hit;
  wire         wr_pow   = we_i && (addr_i == OFS_POWER);

  // link events
  wire         rst_rise   = link_i.bus_reset && !rst_prev_q;
  wire         periph     = !host_q;
  wire         idle_done  = (idle_cnt_q == SUSP_CYC - 1);
  wire         can_idle   = periph && soft_conn_q && !link_i.bus_activity;
  wire         susp_evt   = (st_q == ST_ACTIVE) && can_idle && idle_done && !link_i.bus_reset;
  // a host resume while our own wakeup is being driven is the same resume; stay quiet
  wire         resume_evt = (st_q == ST_SUSPEND) && link_i.resume_sig && !resume_q
                            && !link_i.bus_reset;
  wire         wake_end   = (st_q == ST_SUSPEND) && resume_prev_q && !resume_q;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_ACTIVE: begin
        if (susp_evt) begin
          st_d = ST_SUSPEND;
        end
      end
      ST_SUSPEND: begin
        if (link_i.bus_reset || resume_evt || wake_end) begin
          st_d = ST_ACTIVE;
        end
      end
    endcase
  end

  // interrupt sources; a set in the same cycle as a clear wins
  wire [INT_W-1:0] int_set = {link_i.disconnect, link_i.connect, link_i.sof, rst_rise,
                              resume_evt, susp_evt, xfer_done_i};
  wire [INT_W-1:0] int_clr = (we_i && addr_i == OFS_INT_STS) ?
                             wdata_i[INT_W-1:0] : '0;
  wire [INT_W-1:0] ists_d  = (ists_q & ~int_clr) | int_set;
  wire             irq_d   = |(ists_d & ien_q);

  // endpoint read selection
  wire [31:0] ep_rd = (ep_word == W_CSR)   ? {16'h0000, csr_q[ep_sel]} :
                      (ep_word == W_TXCFG) ? txcfg_q[ep_sel] :
                      (ep_word == W_RXCFG) ? rxcfg_q[ep_sel] : 32'h0000_0000;

  wire [31:0] pow_rd = 32'({soft_conn_q, hs_en_q, hs_act_q, resume_q, 1'b0,
                            st_q == ST_SUSPEND, 1'b0});
  wire [31:0] phy_rd = 32'(phy_q) | (32'(pll_locked_i) << PHY_LOCK_BIT);

  wire [31:0] rd_d = !re_i                     ? 32'h0000_0000 :
                     ep_hit                    ? ep_rd :
                     (addr_i == OFS_FUNCTION_ADDRESS_REG)     ? 32'(function_address_reg_q) :
                     (addr_i == OFS_POWER)     ? pow_rd :
                     (addr_i == OFS_INT_STS)   ? 32'(ists_q) :
                     (addr_i == OFS_INT_EN)    ? 32'(ien_q) :
                     (addr_i == OFS_INDEX)     ? 32'(index_q) :
                     (addr_i == OFS_DEVCTL)    ? 32'(host_q) :
                     (addr_i == OFS_PHY_CTL)   ? phy_rd : 32'h0000_0000;

  wire        reject_d = setup_i.valid && (setup_i.length != SETUP_LEN);
  wire        drive_d  = (st_q == ST_SUSPEND) && resume_q;
  wire        hs_try_d = link_i.bus_reset && hs_en_q && periph;

  // endpoint storage; endpoint zero fifo placement is fixed
  for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
    wire sel = wr_ep && (ep_sel == 3'(e));
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        csr_q[e]   <= 16'h0000;
        txcfg_q[e] <= (e == 0) ? EP0_FIFO_CFG : 32'h0000_0000;
        rxcfg_q[e] <= (e == 0) ? EP0_FIFO_CFG : 32'h0000_0000;
      end else begin
        if (rst_rise) begin
          csr_q[e] <= 16'h0000;
        end else if (sel && ep_word == W_CSR) begin
          csr_q[e] <= wdata_i[15:0];
        end
        if (e != 0 && sel && ep_word == W_TXCFG) begin
          txcfg_q[e] <= wdata_i;
        end
        if (e != 0 && sel && ep_word == W_RXCFG) begin
          rxcfg_q[e] <= wdata_i;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      function_address_reg_q <= 7'h00;
      index_q <= 4'h0;
    end else if (rst_rise) begin
      function_address_reg_q <= 7'h00;
      index_q <= 4'h0;
    end else begin
      if (we_i && addr_i == OFS_FUNCTION_ADDRESS_REG) begin
        function_address_reg_q <= wdata_i[6:0];
      end
      if (we_i && addr_i == OFS_INDEX) begin
        index_q <= wdata_i[3:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      soft_conn_q   <= 1'b0;
      hs_en_q       <= 1'b0;
      resume_q      <= 1'b0;
      resume_prev_q <= 1'b0;
    end else begin
      resume_prev_q <= resume_q;
      if (wr_pow) begin
        soft_conn_q <= wdata_i[POW_SOFT_CONN];
        hs_en_q     <= wdata_i[POW_HS_EN];
        resume_q    <= wdata_i[POW_RESUME];
      end
    end
  end

  // negotiation result is latched while the host holds reset
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hs_act_q <= 1'b0;
    end else if (link_i.bus_reset) begin
      hs_act_q <= hs_en_q && periph && link_i.hs_chirp_ok;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phy_q <= usbc_phy_ctl_s'(PHY_CTL_RST);
    end else if (we_i && addr_i == OFS_PHY_CTL) begin
      phy_q <= usbc_phy_ctl_s'(wdata_i[5:0]);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ists_q <= '0;
      ien_q  <= '0;
      irq_q  <= 1'b0;
    end else begin
      ists_q <= ists_d;
      irq_q  <= irq_d;
      if (we_i && addr_i == OFS_INT_EN) begin
        ien_q <= wdata_i[INT_W-1:0];
      end
    end
  end

  // role follows the cable end every cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      host_q <= 1'b0;
    end else begin
      host_q <= id_a_end_i;
    end
  end

  // idle counter restarts on any activity, reset or leaving peripheral role
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idle_cnt_q <= 32'h0000_0000;
      st_q       <= ST_ACTIVE;
      rst_prev_q <= 1'b0;
    end else begin
      st_q       <= st_d;
      rst_prev_q <= link_i.bus_reset;
      if (st_q != ST_ACTIVE || !can_idle || idle_done || link_i.bus_reset) begin
        idle_cnt_q <= 32'h0000_0000;
      end else begin
        idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q  <= 32'h0000_0000;
      flush_q  <= 5'h00;
      reject_q <= 1'b0;
      drive_q  <= 1'b0;
      hs_try_q <= 1'b0;
    end else begin
      rdata_q  <= rd_d;
      flush_q  <= rst_rise ? 5'h1F : 5'h00;
      reject_q <= reject_d;
      drive_q  <= drive_d;
      hs_try_q <= hs_try_d;
    end
  end

  assign rdata_o        = rdata_q;
  assign phy_ctl_o      = phy_q;
  assign soft_connect_o = soft_conn_q;
  assign host_mode_o    = host_q;
  assign suspend_o      = (st_q == ST_SUSPEND);
  assign resume_drive_o = drive_q;
  assign hs_attempt_o   = hs_try_q;
  assign hs_active_o    = hs_act_q;
  assign fifo_flush_o   = flush_q;
  assign setup_reject_o = reject_q;
  assign function_address_reg_o        = function_address_reg_q;
  assign irq_o          = irq_q;

endmodule

//--- sim/usbc_host_model.sv
`timescale 1ns/10ps
module usbc_host_model
  import usbc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       hs_ok_i,
  input  wire logic       soft_connect_i,
  output usbc_link_evt_s  link_o
);
  logic [4:0] sof_q;
  logic       conn_q;
  // mode 0 idle, 1 traffic with frames, 2 resume, 3 bus reset
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sof_q  <= '0;
      conn_q <= 1'b0;
      link_o <= '0;
    end else begin
      sof_q                <= sof_q + 5'h01;
      conn_q               <= soft_connect_i;
      // resume and reset signalling count as traffic, so idle means silence
      link_o.bus_activity  <= (mode_i != 2'h0);
      link_o.bus_reset     <= (mode_i == 2'h3);
      link_o.resume_sig    <= (mode_i == 2'h2);
      link_o.sof           <= (mode_i == 2'h1) && (sof_q == 5'h00);
      link_o.connect       <= soft_connect_i && !conn_q;
      link_o.disconnect    <= !soft_connect_i && conn_q;
      link_o.hs_chirp_ok   <= hs_ok_i && (mode_i == 2'h3);
    end
  end
endmodule

//--- sim/usbc_core_chk.sv
`timescale 1ns/10ps
module usbc_core_chk
  import usbc_pkg::*;
#(
  parameter int unsigned SUSP_CYC = usbc_pkg::SUSPEND_CYCLES
) (
  input wire logic                      clk_i,
  input wire logic                      arst_n_i,
  input wire logic                      re_i,
  input wire logic      [31:0]          rdata_o,
  input wire usbc_pkg::usbc_link_evt_s  link_i,
  input wire usbc_pkg::usbc_setup_s     setup_i,
  input wire logic                      id_a_end_i,
  input wire logic                      soft_connect_o,
  input wire logic                      host_mode_o,
  input wire logic                      suspend_o,
  input wire logic                      resume_drive_o,
  input wire logic                      hs_attempt_o,
  input wire logic      [4:0]           fifo_flush_o,
  input wire logic                      setup_reject_o,
  input wire logic      [6:0]           function_address_reg_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [31:0] idle_q;
  wire idle_w = !link_i.bus_activity && !link_i.bus_reset && soft_connect_o
                && !host_mode_o && !suspend_o;
  // counts idle cycles as the timer should see them
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) idle_q <= '0;
    else idle_q <= idle_w ? idle_q + 32'h1 : 32'h0;
  end
  sequence s_flush;
    fifo_flush_o == 5'h1F ##1 fifo_flush_o == 5'h00;
  endsequence
  a_rdata_quiet: assert property (!re_i |=> rdata_o == 32'h0)
    else $error("read data outside read cycle");
  a_flush_pulse: assert property ($rose(link_i.bus_reset) |=> s_flush)
    else $error("fifo flush pulse wrong");
  a_reset_clears: assert property (link_i.bus_reset |=> function_address_reg_o == 7'h00 && !suspend_o)
    else $error("bus reset did not clear address");
  a_hs_gate: assert property (hs_attempt_o |-> $past(link_i.bus_reset))
    else $error("negotiation outside bus reset");
  a_setup_bad: assert property (setup_i.valid && setup_i.length != SETUP_LEN |=> setup_reject_o)
    else $error("bad setup not rejected");
  a_setup_good: assert property (setup_reject_o |-> $past(setup_i.valid)
      && $past(setup_i.length) != SETUP_LEN)
    else $error("reject without bad setup");
  a_role_follow: assert property (##1 host_mode_o == $past(id_a_end_i))
    else $error("role does not follow cable end");
  a_susp_early: assert property ($rose(suspend_o) |-> idle_q inside {[SUSP_CYC-1:SUSP_CYC+2]})
    else $error("suspend at wrong idle time");
  a_susp_late: assert property (idle_q <= SUSP_CYC + 2)
    else $error("suspend missing after idle");
  a_resume_exit: assert property (link_i.resume_sig && suspend_o && !resume_drive_o
      |=> !suspend_o)
    else $error("resume did not leave suspend");
  a_wake_drive: assert property (resume_drive_o |-> $past(suspend_o))
    else $error("resume drive while awake");
endmodule
bind usbc_core usbc_core_chk #(.SUSP_CYC(SUSP_CYC)) u_chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .re_i(re_i), .rdata_o(rdata_o), .link_i(link_i),
  .setup_i(setup_i), .id_a_end_i(id_a_end_i), .soft_connect_o(soft_connect_o),
  .host_mode_o(host_mode_o), .suspend_o(suspend_o), .resume_drive_o(resume_drive_o),
  .hs_attempt_o(hs_attempt_o), .fifo_flush_o(fifo_flush_o),
  .setup_reject_o(setup_reject_o), .function_address_reg_o(function_address_reg_o));

//--- sim/tb.sv
`timescale 1ns/10ps
module tb;
  import usbc_pkg::*;
  localparam int unsigned SC = 20;
  logic           clk_i = 1'b0;
  logic           arst_n_i = 1'b0;
  logic [11:0]    addr_i = '0;
  logic [31:0]    wdata_i = '0;
  logic           we_i = 1'b0;
  logic           re_i = 1'b0;
  logic [31:0]    rdata_o;
  usbc_link_evt_s link;
  usbc_setup_s    setup_i = '0;
  logic [4:0]     xfer_done_i = '0;
  logic           id_a_end_i = 1'b0;
  logic           pll_locked_i = 1'b0;
  usbc_phy_ctl_s  phy_ctl_o;
  logic           soft_connect_o, host_mode_o, suspend_o, resume_drive_o;
  logic           hs_attempt_o, hs_active_o, setup_reject_o, irq_o;
  logic [4:0]     fifo_flush_o;
  logic [6:0]     function_address_reg_o;
  logic [1:0]     mode = 2'h1;
  logic           hs_ok = 1'b0;
  int             miscompares = 0;
  int             samples_checked = 0;
  int             seed = 32'h0de0;
  logic [31:0]    cfg_m [5];
  logic [31:0]    v;
  localparam logic [31:0] PW = 32'h60;
  always #4 clk_i = ~clk_i;
  usbc_core #(.SUSP_CYC(SC)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .link_i(link),
    .setup_i(setup_i), .xfer_done_i(xfer_done_i), .id_a_end_i(id_a_end_i),
    .pll_locked_i(pll_locked_i), .phy_ctl_o(phy_ctl_o), .soft_connect_o(soft_connect_o),
    .host_mode_o(host_mode_o), .suspend_o(suspend_o), .resume_drive_o(resume_drive_o),
    .hs_attempt_o(hs_attempt_o), .hs_active_o(hs_active_o), .fifo_flush_o(fifo_flush_o),
    .setup_reject_o(setup_reject_o), .function_address_reg_o(function_address_reg_o), .irq_o(irq_o));
  usbc_host_model host (.clk_i(clk_i), .arst_n_i(arst_n_i), .mode_i(mode), .hs_ok_i(hs_ok),
    .soft_connect_i(soft_connect_o), .link_o(link));
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
    #1;
  endtask
  // read data live only in the cycle after the strobe
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 chk(n, rdata_o & m, e);
  endtask
  task automatic setm(input logic [1:0] m);
    @(posedge clk_i);
    mode <= m;
    hs_ok <= (m == 2'h3);
  endtask
  // bounded wait so a stuck timer cannot hang the run
  task automatic wait_susp(input logic e);
    for (int i = 0; i < 4 * SC && suspend_o !== e; i++) @(posedge clk_i) #1;
    chk("suspend", suspend_o, e);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(8 * 20000);
    miscompares++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rdc("power", OFS_POWER, '1, 32'h0);
    chk("soft_conn", soft_connect_o, 32'h0);
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      @(posedge clk_i);
      pll_locked_i <= v[8];
      wr(OFS_PHY_CTL, v);
      chk("phy_ctl", phy_ctl_o, v & 32'h3F);
      rdc("phy_rd", OFS_PHY_CTL, 32'h1FF, v & 32'h13F);
    end
    cfg_m[0] = EP0_FIFO_CFG;
    for (int e = 1; e < 5; e++) begin
      cfg_m[e] = $random(seed);
      wr(OFS_INDEX, e);
      wr(OFS_IDX_WIN + 12'h004, cfg_m[e]);
    end
    wr(OFS_FLAT_LO + 12'h004, 32'h1234);
    for (int e = 0; e < 5; e++) begin
      rdc("flat_tx", OFS_FLAT_LO + 12'(e * 16 + 4), '1, cfg_m[e]);
      wr(OFS_INDEX, e);
      rdc("idx_tx", OFS_IDX_WIN + 12'h004, '1, cfg_m[e]);
    end
    wr(OFS_INDEX, 5);
    rdc("idx_5", OFS_IDX_WIN + 12'h004, '1, 32'h0);
    rdc("unmapped", 12'h300, '1, 32'h0);
    wr(OFS_FUNCTION_ADDRESS_REG, 32'h35);
    wr(OFS_INT_EN, 32'h1 << INT_SUSPEND);
    wr(OFS_POWER, (32'h1 << POW_SOFT_CONN) | (32'h1 << POW_HS_EN));
    chk("soft_on", soft_connect_o, 32'h1);
    setm(2'h0);
    wr(OFS_INT_STS, 32'h7FF);
    wait_susp(1'b1);
    rdc("ists_susp", OFS_INT_STS, PW, 32'h20);
    chk("irq", irq_o, 32'h1);
    wr(OFS_INT_STS, 32'h7FF);
    setm(2'h2);
    wait_susp(1'b0);
    setm(2'h1);
    rdc("ists_res", OFS_INT_STS, PW, 32'h40);
    setm(2'h0);
    wait_susp(1'b1);
    wr(OFS_INT_STS, 32'h7FF);
    wr(OFS_POWER, 32'h68);
    @(posedge clk_i) #1 chk("res_drv", resume_drive_o, 32'h1);
    repeat (5) @(posedge clk_i);
    wr(OFS_POWER, 32'h60);
    wait_susp(1'b0);
    setm(2'h1);
    chk("res_off", resume_drive_o, 32'h0);
    rdc("ists_wake", OFS_INT_STS, PW, 32'h0);
    wr(OFS_INDEX, 2);
    wr(OFS_IDX_WIN, 32'hA5C3);
    wr(OFS_INT_STS, 32'h7FF);
    setm(2'h3);
    repeat (4) @(posedge clk_i) #1;
    chk("hs_act", hs_active_o, 32'h1);
    chk("function_address_reg", function_address_reg_o, 32'h0);
    setm(2'h1);
    rdc("index", OFS_INDEX, '1, 32'h0);
    rdc("csr2", OFS_FLAT_LO + 12'h020, 32'hFFFF, 32'h0);
    rdc("hs_bit", OFS_POWER, 32'h10, 32'h10);
    rdc("ists_rst", OFS_INT_STS, 32'h80, 32'h80);
    for (int n = 0; n < 16; n++) begin
      @(posedge clk_i);
      setup_i <= '{valid: 1'b1, length: n[3:0]};
      @(posedge clk_i);
      setup_i <= '0;
      #1 chk("reject", setup_reject_o, 32'(n != 8));
    end
    wr(OFS_INT_STS, 32'h7FF);
    v = $random(seed);
    @(posedge clk_i);
    xfer_done_i <= v[4:0];
    @(posedge clk_i);
    xfer_done_i <= 5'h00;
    rdc("ep_done", OFS_INT_STS, 32'h1F, v & 32'h1F);
    chk("irq_mask", irq_o, 32'h0);
    @(posedge clk_i);
    id_a_end_i <= 1'b1;
    rdc("role", OFS_DEVCTL, 32'h1, 32'h1);
    chk("host", host_mode_o, 32'h1);
    stop_test;
  end
endmodule
